// File: src/gpc_pkg.sv
// package: register offsets, reset values and pin mode encodings for the port block
package gpc_pkg;
  // register offsets on the software port
  localparam logic [7:0] GPC_OFS_PA_VALUE = 8'hc0;
  localparam logic [7:0] GPC_OFS_PB_VALUE = 8'hc1;
  localparam logic [7:0] GPC_OFS_PC_VALUE = 8'hc2;
  localparam logic [7:0] GPC_OFS_PA_DIR = 8'hc4;
  localparam logic [7:0] GPC_OFS_PB_DIR = 8'hc5;
  localparam logic [7:0] GPC_OFS_PC_DIR = 8'hc6;
  localparam logic [7:0] GPC_OFS_PA_OPT = 8'hcc;
  localparam logic [7:0] GPC_OFS_PB_OPT = 8'hcd;
  localparam logic [7:0] GPC_OFS_PC_OPT = 8'hce;
  localparam logic [7:0] GPC_OFS_MISC = 8'hdd;
  // reset values: all cleared, input with pull-up
  localparam logic [7:0] GPC_RST_PORT = 8'h00;
  localparam logic [7:0] GPC_RST_MISC = 8'h00;
  // field positions
  localparam int GPC_MISC_SERIAL_OUT_PIN_BIT = 0;
  localparam int GPC_PB_PWM_BIT = 7;
  localparam int GPC_PB_TIN_BIT = 6;
  localparam int GPC_PC_SIN_BIT = 2;
  localparam int GPC_PC_SERIAL_OUT_PIN_BIT = 3;
  localparam int GPC_PC_SCK_BIT = 4;
  localparam int GPC_NPORTS = 3;
  // per-pin mode from direction, option, data
  typedef enum logic [2:0]
  {
    GPC_IN_PULLUP = 3'h0,
    GPC_IN_FLOAT = 3'h1,
    GPC_IN_IRQ = 3'h2,
    GPC_IN_ANALOG = 3'h3,
    GPC_OUT_OD = 3'h4,
    GPC_OUT_PP = 3'h5
  } gpc_mode_t;
endpackage : gpc_pkg

// File: src/gpc_cfg_if.sv
// interface: one port's configuration and its pin-side results
`timescale 1ns/1ps
interface gpc_cfg_if;
  logic [7:0] dir;
  logic [7:0] opt;
  logic [7:0] val;
  logic [7:0] sync_pin;
  logic [7:0] pull_en;
  logic [7:0] irq_en;
  logic [7:0] analog_en;
  logic [7:0] out_drv;
  logic [7:0] out_oe;
  modport ctl (output dir, opt, val, input sync_pin, pull_en, irq_en, analog_en, out_drv, out_oe);
  modport pin (input dir, opt, val, output sync_pin, pull_en, irq_en, analog_en, out_drv, out_oe);
endinterface : gpc_cfg_if

// File: src/gpc_sync.sv
// two-stage synchroniser for a byte of pin levels
`timescale 1ns/1ps
module gpc_sync
  import gpc_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // raw and synchronised levels
  input wire logic [7:0] raw_in,
  output logic [7:0] sync_out
);
  logic [7:0] st1_reg;
  logic [7:0] st1_next;
  logic [7:0] st2_reg;
  logic [7:0] st2_next;

  // first stage feeds only the second
  always_comb
  begin
    st1_next = raw_in;
    st2_next = st1_reg;
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      st1_reg <= GPC_RST_PORT;
      st2_reg <= GPC_RST_PORT;
    end
    else
    begin
      st1_reg <= st1_next;
      st2_reg <= st2_next;
    end
  end

  assign sync_out = st2_reg;
endmodule : gpc_sync

// File: src/gpc_pin_cell.sv
// pin cell: decodes each pin's mode and drives pull-up, interrupt, analog and output controls
`timescale 1ns/1ps
module gpc_pin_cell
  import gpc_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // raw pad levels
  input wire logic [7:0] pad_in,
  // configuration side
  gpc_cfg_if.pin cfg
);
  logic [7:0] pull_reg;
  logic [7:0] pull_next;
  logic [7:0] irq_reg;
  logic [7:0] irq_next;
  logic [7:0] ana_reg;
  logic [7:0] ana_next;
  logic [7:0] drv_reg;
  logic [7:0] drv_next;
  logic [7:0] oe_reg;
  logic [7:0] oe_next;

  // decoding shared by every bit
  function automatic gpc_mode_t mode_of(input logic d, input logic o, input logic v);
    gpc_mode_t m;
    m = GPC_IN_PULLUP;
    if (d)
      m = o ? GPC_OUT_PP : GPC_OUT_OD;
    else
      m = gpc_mode_t'({1'b0, o, v});
    return m;
  endfunction : mode_of

  gpc_sync u_sync
  (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .raw_in(pad_in),
    .sync_out(cfg.sync_pin)
  );

  // per-bit control decode
  always_comb
  begin
    pull_next = '0;
    irq_next = '0;
    ana_next = '0;
    drv_next = '0;
    oe_next = '0;
    for (int i = 0; i < 8; i++)
    begin
      case (mode_of(cfg.dir[i], cfg.opt[i], cfg.val[i]))
        GPC_IN_PULLUP: pull_next[i] = 1'b1;
        GPC_IN_FLOAT: pull_next[i] = 1'b0;
        GPC_IN_IRQ:
        begin
          pull_next[i] = 1'b1;
          irq_next[i] = 1'b1;
        end
        GPC_IN_ANALOG: ana_next[i] = 1'b1;
        GPC_OUT_OD: oe_next[i] = ~cfg.val[i];
        GPC_OUT_PP: oe_next[i] = 1'b1;
        default: pull_next[i] = 1'b1;
      endcase
      drv_next[i] = cfg.dir[i] & cfg.val[i];
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      pull_reg <= '1;
      irq_reg <= '0;
      ana_reg <= '0;
      drv_reg <= '0;
      oe_reg <= '0;
    end
    else
    begin
      pull_reg <= pull_next;
      irq_reg <= irq_next;
      ana_reg <= ana_next;
      drv_reg <= drv_next;
      oe_reg <= oe_next;
    end
  end

  assign cfg.pull_en = pull_reg;
  assign cfg.irq_en = irq_reg;
  assign cfg.analog_en = ana_reg;
  assign cfg.out_drv = drv_reg;
  assign cfg.out_oe = oe_reg;
endmodule : gpc_pin_cell

// File: src/gpc_port_top.sv
// top: three byte ports, their registers and the timer and serial alternate functions
//
// What this block does
// - dir 0, opt 0: input; data 0 pull-up, data 1 floating, no interrupt.
// - dir 0, opt 1: data 0 interrupt input with pull-up, data 1 analog.
// - dir 1: drive latched data; opt 0 open-drain, opt 1 push-pull.
// - interrupt-capable inputs feed the interrupt system; trigger chosen elsewhere.
// - analog inputs route through the multiplexer to the converter.
// - data reads return live pin level for inputs; writes always update latch.
// - pwm enable high makes port B bit 7 drive the pwm waveform.
// - port B bit 6 always feeds the reload-timer input.
// - port C bits 2 and 4 are plain I/O while clock-drive select is low.
// - port C bit 2 as input feeds the serial shift input.
// - misc bit 0 makes port C bit 3 the push-pull serial output.
// - port C bit 4 push-pull with clock-drive select drives the master clock.
// - port C bit 4 input with select clear supplies slave clock, stays readable.
// - reset clears all port registers: inputs with pull-up, no interrupt.
`timescale 1ns/1ps
module gpc_port_top
  import gpc_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // software register port
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  // pads of ports A, B, C
  input wire logic [7:0] pa_pad_in,
  input wire logic [7:0] pb_pad_in,
  input wire logic [7:0] pc_pad_in,
  output logic [7:0] pa_drv_out,
  output logic [7:0] pa_oe_out,
  output logic [7:0] pa_pull_out,
  output logic [7:0] pb_drv_out,
  output logic [7:0] pb_oe_out,
  output logic [7:0] pb_pull_out,
  output logic [7:0] pc_drv_out,
  output logic [7:0] pc_oe_out,
  output logic [7:0] pc_pull_out,
  // interrupt and analog routing
  output logic [7:0] pa_irq_level_out,
  output logic [7:0] pb_irq_level_out,
  output logic [7:0] pc_irq_level_out,
  output logic [23:0] analog_sel_out,
  // reload timer alternate functions
  input wire logic pwm_pin_enable_in,
  input wire logic reload_timer_pwm_in,
  output logic reload_timer_in_pin_out,
  // serial alternate functions
  input wire logic serial_clock_drive_sel_in,
  input wire logic serial_data_in,
  input wire logic serial_master_clk_in,
  output logic serial_shift_in_out,
  output logic serial_slave_clk_out
);
  logic [7:0] dir_reg [GPC_NPORTS];
  logic [7:0] dir_next [GPC_NPORTS];
  logic [7:0] opt_reg [GPC_NPORTS];
  logic [7:0] opt_next [GPC_NPORTS];
  logic [7:0] val_reg [GPC_NPORTS];
  logic [7:0] val_next [GPC_NPORTS];
  logic [7:0] misc_control_reg;
  logic [7:0] misc_control_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [7:0] pad [GPC_NPORTS];
  logic [7:0] live [GPC_NPORTS];
  logic [7:0] pull [GPC_NPORTS];
  logic [7:0] irq [GPC_NPORTS];
  logic [7:0] ana [GPC_NPORTS];
  logic [7:0] drv [GPC_NPORTS];
  logic [7:0] oe [GPC_NPORTS];

  // output bits read back the latch, input bits the synchronised pad
  function automatic logic [7:0] readback(input logic [7:0] d, input logic [7:0] v, input logic [7:0] l);
    return (d & v) | (~d & l);
  endfunction : readback

  assign pad[0] = pa_pad_in;
  assign pad[1] = pb_pad_in;
  assign pad[2] = pc_pad_in;

  // one pin cell per port
  genvar g;
  generate
    for (g = 0; g < GPC_NPORTS; g++)
    begin : g_port
      gpc_cfg_if cfg_if ();
      assign cfg_if.dir = dir_reg[g];
      assign cfg_if.opt = opt_reg[g];
      assign cfg_if.val = val_reg[g];
      assign live[g] = cfg_if.sync_pin;
      assign pull[g] = cfg_if.pull_en;
      assign irq[g] = cfg_if.irq_en;
      assign ana[g] = cfg_if.analog_en;
      assign drv[g] = cfg_if.out_drv;
      assign oe[g] = cfg_if.out_oe;
      gpc_pin_cell u_cell
      (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .pad_in(pad[g]),
        .cfg(cfg_if.pin)
      );
    end
  endgenerate

  // register writes; unmapped addresses leave every register alone
  always_comb
  begin
    for (int p = 0; p < GPC_NPORTS; p++)
    begin
      dir_next[p] = dir_reg[p];
      opt_next[p] = opt_reg[p];
      val_next[p] = val_reg[p];
    end
    misc_control_next = misc_control_reg;
    if (wr_in)
    begin
      case (addr_in)
        // write always lands in the latch
        GPC_OFS_PA_VALUE: val_next[0] = wdata_in;
        GPC_OFS_PB_VALUE: val_next[1] = wdata_in;
        GPC_OFS_PC_VALUE: val_next[2] = wdata_in;
        GPC_OFS_PA_DIR: dir_next[0] = wdata_in;
        GPC_OFS_PB_DIR: dir_next[1] = wdata_in;
        GPC_OFS_PC_DIR: dir_next[2] = wdata_in;
        GPC_OFS_PA_OPT: opt_next[0] = wdata_in;
        GPC_OFS_PB_OPT: opt_next[1] = wdata_in;
        GPC_OFS_PC_OPT: opt_next[2] = wdata_in;
        GPC_OFS_MISC: misc_control_next = wdata_in;
        default: misc_control_next = misc_control_reg;
      endcase
    end
  end

  // read path: data only in the cycle after the strobe, zero otherwise
  always_comb
  begin
    rdata_next = 8'h00;
    if (rd_in)
    begin
      case (addr_in)
        GPC_OFS_PA_VALUE: rdata_next = readback(dir_reg[0], val_reg[0], live[0]);
        GPC_OFS_PB_VALUE: rdata_next = readback(dir_reg[1], val_reg[1], live[1]);
        GPC_OFS_PC_VALUE: rdata_next = readback(dir_reg[2], val_reg[2], live[2]);
        GPC_OFS_PA_DIR: rdata_next = dir_reg[0];
        GPC_OFS_PB_DIR: rdata_next = dir_reg[1];
        GPC_OFS_PC_DIR: rdata_next = dir_reg[2];
        GPC_OFS_PA_OPT: rdata_next = opt_reg[0];
        GPC_OFS_PB_OPT: rdata_next = opt_reg[1];
        GPC_OFS_PC_OPT: rdata_next = opt_reg[2];
        GPC_OFS_MISC: rdata_next = misc_control_reg;
        default: rdata_next = 8'h00; // unmapped reads as zero
      endcase
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      for (int p = 0; p < GPC_NPORTS; p++)
      begin
        dir_reg[p] <= GPC_RST_PORT;
        opt_reg[p] <= GPC_RST_PORT;
        val_reg[p] <= GPC_RST_PORT;
      end
      misc_control_reg <= GPC_RST_MISC;
    end
    else
    begin
      for (int p = 0; p < GPC_NPORTS; p++)
      begin
        dir_reg[p] <= dir_next[p];
        opt_reg[p] <= opt_next[p];
        val_reg[p] <= val_next[p];
      end
      misc_control_reg <= misc_control_next;
    end
  end

  // read data register, cleared by reset
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      rdata_reg <= 8'h00;
    else
      rdata_reg <= rdata_next;
  end

  assign rdata_out = rdata_reg;

  // interrupt-capable inputs carry their live level
  assign pa_irq_level_out = irq[0] & live[0];
  assign pb_irq_level_out = irq[1] & live[1];
  assign pc_irq_level_out = irq[2] & live[2];
  // analog select lines to the converter mux; one at a time is software's duty
  assign analog_sel_out = {ana[2], ana[1], ana[0]};

  // port A has no alternate function
  assign pa_drv_out = drv[0];
  assign pa_oe_out = oe[0];
  assign pa_pull_out = pull[0];

  // port B with pwm override on bit 7; override is combinational so the waveform is not delayed
  always_comb
  begin
    pb_drv_out = drv[1];
    pb_oe_out = oe[1];
    pb_pull_out = pull[1];
    if (pwm_pin_enable_in)
    begin
      pb_drv_out[GPC_PB_PWM_BIT] = reload_timer_pwm_in;
      pb_oe_out[GPC_PB_PWM_BIT] = 1'b1;
      pb_pull_out[GPC_PB_PWM_BIT] = 1'b0;
    end
  end
  // bit 6 always feeds timer input
  assign reload_timer_in_pin_out = live[1][GPC_PB_TIN_BIT];

  // port C with serial overrides
  always_comb
  begin
    pc_drv_out = drv[2];
    pc_oe_out = oe[2];
    pc_pull_out = pull[2];
    if (misc_control_reg[GPC_MISC_SERIAL_OUT_PIN_BIT])
    begin
      pc_drv_out[GPC_PC_SERIAL_OUT_PIN_BIT] = serial_data_in;
      pc_oe_out[GPC_PC_SERIAL_OUT_PIN_BIT] = 1'b1;
      pc_pull_out[GPC_PC_SERIAL_OUT_PIN_BIT] = 1'b0;
    end
    // master clock on push-pull bit 4
    if (serial_clock_drive_sel_in && dir_reg[2][GPC_PC_SCK_BIT] && opt_reg[2][GPC_PC_SCK_BIT])
    begin
      pc_drv_out[GPC_PC_SCK_BIT] = serial_master_clk_in;
      pc_oe_out[GPC_PC_SCK_BIT] = 1'b1;
    end
  end

  // bit 2 input feeds shift register
  assign serial_shift_in_out = ~dir_reg[2][GPC_PC_SIN_BIT] & live[2][GPC_PC_SIN_BIT];
  // slave clock from input bit 4
  assign serial_slave_clk_out = ~dir_reg[2][GPC_PC_SCK_BIT] & ~serial_clock_drive_sel_in
                                & live[2][GPC_PC_SCK_BIT];
endmodule : gpc_port_top

// File: verification/gpc_pad_model.sv
// board model of one port's pads
`timescale 1ns/1ps
module gpc_pad_model
(
  // clock
  input wire logic clk_in,
  // device side
  input wire logic [7:0] drv_in,
  input wire logic [7:0] oe_in,
  input wire logic [7:0] pull_in,
  // board side
  input wire logic [7:0] ext_en_in,
  input wire logic [7:0] ext_val_in,
  output logic [7:0] pad_out
);
  logic [7:0] wander_reg = 8'h55;
  // a floating pad changes every cycle, so no stale level passes by luck
  always_ff @(posedge clk_in)
    wander_reg <= ~wander_reg;
  // device drive wins, then board, then pull-up
  always_comb
    pad_out = (oe_in & drv_in) | (~oe_in & ext_en_in & ext_val_in) | (~oe_in & ~ext_en_in & pull_in)
      | (~oe_in & ~ext_en_in & ~pull_in & wander_reg);
endmodule : gpc_pad_model

// File: verification/gpc_port_top_properties.sv
// port block assertions, bound to the top
`timescale 1ns/1ps
module gpc_port_top_properties
(
  // clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // observed ports
  input wire logic rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic [7:0] pa_oe_out,
  input wire logic [7:0] pa_pull_out,
  input wire logic [7:0] pa_irq_level_out,
  input wire logic [7:0] pb_pad_in,
  input wire logic [7:0] pb_drv_out,
  input wire logic [7:0] pb_oe_out,
  input wire logic [7:0] pb_pull_out,
  input wire logic [23:0] analog_sel_out,
  input wire logic pwm_pin_enable_in,
  input wire logic reload_timer_pwm_in,
  input wire logic reload_timer_in_pin_out,
  input wire logic serial_clock_drive_sel_in,
  input wire logic serial_slave_clk_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);
  // reset is watched while it is asserted, so no disable here
  AST_RESET_STATE: assert property (disable iff (1'b0) srst_in [*2] |-> pa_pull_out == 8'hff
    && pa_oe_out == 8'h00 && analog_sel_out == 24'h000000 && rdata_out == 8'h00) else $error("not cleared in reset");
  AST_RDATA_IDLE: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
    else $error("read data outside read slot");
  AST_IRQ_PULL: assert property ((pa_irq_level_out & ~pa_pull_out) == 8'h00)
    else $error("interrupt pin without pull-up");
  AST_IRQ_INPUT: assert property ((pa_irq_level_out & pa_oe_out) == 8'h00)
    else $error("interrupt pin is driven");
  AST_ANALOG_ALONE: assert property ((analog_sel_out[7:0] & (pa_pull_out | pa_oe_out | pa_irq_level_out))
    == 8'h00) else $error("analog pin not isolated");
  AST_PWM_OVERRIDE: assert property (pwm_pin_enable_in |-> pb_oe_out[7] && !pb_pull_out[7]
    && pb_drv_out[7] == reload_timer_pwm_in) else $error("pwm not on port B bit 7");
  // two-flop delay; first edges after reset still hold cleared stages
  AST_TIMER_IN: assert property (!$past(srst_in) && !$past(srst_in, 2)
    |-> reload_timer_in_pin_out == $past(pb_pad_in[6], 2)) else $error("timer input not two cycles behind pad");
  AST_SLAVE_CLK: assert property (serial_clock_drive_sel_in && $past(serial_clock_drive_sel_in)
    |-> !serial_slave_clk_out) else $error("slave clock while master selected");
  COV_PWM: cover property (pwm_pin_enable_in && reload_timer_pwm_in);
  COV_IRQ: cover property (pa_irq_level_out != 8'h00);
  COV_SLAVE: cover property (serial_slave_clk_out);
endmodule : gpc_port_top_properties
bind gpc_port_top gpc_port_top_properties chk_u (.clk_in(clk_in), .srst_in(srst_in), .rd_in(rd_in),
  .rdata_out(rdata_out), .pa_oe_out(pa_oe_out), .pa_pull_out(pa_pull_out), .pa_irq_level_out(pa_irq_level_out),
  .pb_pad_in(pb_pad_in), .pb_drv_out(pb_drv_out), .pb_oe_out(pb_oe_out), .pb_pull_out(pb_pull_out),
  .analog_sel_out(analog_sel_out), .pwm_pin_enable_in(pwm_pin_enable_in), .reload_timer_pwm_in(reload_timer_pwm_in),
  .reload_timer_in_pin_out(reload_timer_in_pin_out), .serial_clock_drive_sel_in(serial_clock_drive_sel_in),
  .serial_slave_clk_out(serial_slave_clk_out));

// File: verification/gpc_port_top_tb_top.sv
// self-checking bench for the port block
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin failures++; $display("[FAIL] %0t %h!=%h", $time, g, e); end end
module gpc_port_top_tb_top
  import gpc_pkg::*;
;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic [7:0] addr_in = 8'h00, wdata_in = 8'h00, rdata_out;
  logic wr_in = 1'b0, rd_in = 1'b0, pwm_en = 1'b0, pwm_val = 1'b0, sel = 1'b0, sdata = 1'b0, mclk = 1'b0;
  logic tin, shift_in, slave_clk;
  logic [23:0] analog_sel_out;
  logic [7:0] drv [3], oe [3], pull [3], pad [3], irq [3];
  logic [7:0] ext_en [3] = '{8'h00, 8'h00, 8'h00};
  logic [7:0] ext_val [3] = '{8'h00, 8'h00, 8'h00};
  logic [7:0] zero_ofs [8] = '{GPC_OFS_PA_DIR, GPC_OFS_PB_DIR, GPC_OFS_PC_DIR, GPC_OFS_PA_OPT, GPC_OFS_PB_OPT,
    GPC_OFS_PC_OPT, GPC_OFS_MISC, 8'h00};
  int failures = 0, checked = 0, cycles = 0;
  initial
    forever #2.5 clk_in = ~clk_in;
  gpc_port_top dut_u (.clk_in(clk_in), .srst_in(srst_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
    .rd_in(rd_in), .rdata_out(rdata_out), .pa_pad_in(pad[0]), .pb_pad_in(pad[1]), .pc_pad_in(pad[2]),
    .pa_drv_out(drv[0]), .pa_oe_out(oe[0]), .pa_pull_out(pull[0]), .pb_drv_out(drv[1]), .pb_oe_out(oe[1]),
    .pb_pull_out(pull[1]), .pc_drv_out(drv[2]), .pc_oe_out(oe[2]), .pc_pull_out(pull[2]),
    .pa_irq_level_out(irq[0]), .pb_irq_level_out(irq[1]), .pc_irq_level_out(irq[2]), .analog_sel_out(analog_sel_out),
    .pwm_pin_enable_in(pwm_en), .reload_timer_pwm_in(pwm_val), .reload_timer_in_pin_out(tin),
    .serial_clock_drive_sel_in(sel), .serial_data_in(sdata), .serial_master_clk_in(mclk),
    .serial_shift_in_out(shift_in), .serial_slave_clk_out(slave_clk));
  for (genvar i = 0; i < 3; i++)
  begin : g_pad
    gpc_pad_model pad_u (.clk_in(clk_in), .drv_in(drv[i]), .oe_in(oe[i]), .pull_in(pull[i]),
      .ext_en_in(ext_en[i]), .ext_val_in(ext_val[i]), .pad_out(pad[i]));
  end
  // one-cycle write, idle cycle after so strobes never double-assign
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : wr
  // read data is only valid the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    `CHK(rdata_out & m, e)
  endtask : rd
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : tick
  task automatic board(input int p, input logic [7:0] en, input logic [7:0] v);
    @(posedge clk_in);
    ext_en[p] <= en;
    ext_val[p] <= v;
  endtask : board
  task automatic end_sim();
    $display("failures=%0d checked=%0d", failures, checked);
    if (failures == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  // hang guard, about a hundred cycles expected
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      failures++;
      end_sim();
    end
  end
  initial
  begin
    repeat (3) @(posedge clk_in);
    srst_in <= 1'b0;
    wr(8'h00, 8'hff);
    foreach (zero_ofs[i]) rd(zero_ofs[i], 8'h00, 8'hff);
    rd(GPC_OFS_PB_VALUE, 8'hff, 8'hff);
    `CHK(pull[2], 8'hff)
    // port A: one pin per input mode, two per output mode; direction first so only one analog pin ever exists
    board(0, 8'h06, 8'h04);
    wr(GPC_OFS_PA_DIR, 8'hf0);
    wr(GPC_OFS_PA_VALUE, 8'h6a);
    wr(GPC_OFS_PA_OPT, 8'hcc);
    tick(3);
    `CHK(pull[0][3:0], 4'h5)
    `CHK(oe[0], 8'hd0)
    `CHK(drv[0] & oe[0], 8'h40)
    `CHK(analog_sel_out, 24'h000008)
    `CHK(irq[0], 8'h04)
    rd(GPC_OFS_PA_VALUE, 8'h65, 8'hf7);
    board(0, 8'h06, 8'h06);
    tick(3);
    rd(GPC_OFS_PA_VALUE, 8'h67, 8'hf7);
    wr(GPC_OFS_PA_DIR, 8'hff);
    tick(3);
    rd(GPC_OFS_PA_VALUE, 8'h6a, 8'hff);
    // port B: timer input follows a low pad, board-driven against the pull-up as input, device-driven as output
    board(1, 8'h40, 8'h00);
    tick(3);
    `CHK(tin, 1'b0)
    board(1, 8'h00, 8'h00);
    wr(GPC_OFS_PB_DIR, 8'hc0);
    wr(GPC_OFS_PB_OPT, 8'hc1);
    wr(GPC_OFS_PB_VALUE, 8'h80);
    tick(4);
    `CHK(tin, 1'b0)
    `CHK(irq[1], 8'h01)
    @(posedge clk_in);
    pwm_en <= 1'b1;
    tick(1);
    `CHK(drv[1][7], 1'b0)
    @(posedge clk_in);
    pwm_en <= 1'b0;
    tick(1);
    `CHK(drv[1][7], 1'b1)
    // port C: serial input at both levels, slave clock, serial output, master clock
    board(2, 8'h14, 8'h10);
    tick(3);
    `CHK(shift_in, 1'b0)
    `CHK(slave_clk, 1'b1)
    rd(GPC_OFS_PC_VALUE, 8'h10, 8'h14);
    @(posedge clk_in);
    sel <= 1'b1;
    sdata <= 1'b1;
    ext_val[2] <= 8'h14;
    tick(3);
    `CHK(slave_clk, 1'b0)
    `CHK(shift_in, 1'b1)
    wr(GPC_OFS_MISC, 8'h01);
    tick(2);
    `CHK({oe[2][3], drv[2][3]}, 2'h3)
    rd(GPC_OFS_MISC, 8'h01, 8'hff);
    board(2, 8'h00, 8'h00);
    wr(GPC_OFS_PC_OPT, 8'h15);
    wr(GPC_OFS_PC_DIR, 8'h14);
    @(posedge clk_in);
    mclk <= 1'b1;
    tick(3);
    `CHK({oe[2][4], drv[2][4], shift_in}, 3'h6)
    `CHK(irq[2], 8'h01)
    @(posedge clk_in);
    sel <= 1'b0;
    tick(3);
    `CHK({oe[2][4], drv[2][4]}, 2'h2)
    // second reset in mid-run, released on a rising edge
    @(posedge clk_in);
    srst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    srst_in <= 1'b0;
    rd(GPC_OFS_PC_DIR, 8'h00, 8'hff);
    `CHK({oe[2], pull[2]}, 16'h00ff)
    end_sim();
  end
endmodule : gpc_port_top_tb_top
